// ===== logic/cie_defines.vh
// Constants for the interrupt entry and return block.
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH
// Register offsets in data space.
`define CIE_OFS_PEND       7'h5a
`define CIE_OFS_ENABLE     7'h5b
`define CIE_OFS_SP_LOW     7'h5d
`define CIE_OFS_SP_HIGH    7'h5e
`define CIE_OFS_CORE_FLAGS 7'h5f
// Core flag bit positions.
`define CIE_BIT_GIE   7
`define CIE_BIT_T     6
`define CIE_BIT_H     5
`define CIE_BIT_S     4
`define CIE_BIT_V     3
`define CIE_BIT_N     2
`define CIE_BIT_Z     1
`define CIE_BIT_C     0
// Reset values.
`define CIE_RST_FLAGS  8'h00
`define CIE_RST_ENABLE 8'h00
`define CIE_RST_PEND   8'h00
// Cycle counts.
`define CIE_ENTRY_CYCLES  3'h4
`define CIE_RETURN_CYCLES 3'h4
`define CIE_WAKE_EXTRA    3'h4
`define CIE_JUMP_CYCLES   3'h3
`endif

// ===== logic/cie_pend.v
// Latched pending flags of the flag-type sources.
`timescale 1ns/1ns
module cie_pend #(
    parameter N = 4
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Events and clears
    input  wire [N-1:0] event_in,
    input  wire [N-1:0] sw_clear,
    input  wire [N-1:0] hw_ack,
    // State
    output reg  [N-1:0] pend_reg
);

    wire [N-1:0] pend_next;

    // A new event beats a clear in the same cycle, so no edge is lost.
    assign pend_next = (pend_reg & ~sw_clear & ~hw_ack) | event_in;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= {N{1'b0}};
        end else begin
            pend_reg <= pend_next;
        end
    end

endmodule // cie_pend

// ===== logic/cie_prio.v
// Fixed priority pick among enabled requests.
`timescale 1ns/1ns
module cie_prio #(
    parameter N = 6
) (
    // Requests
    input  wire [N-1:0] req,
    input  wire         gie,
    // Winner
    output wire         any,
    output wire [7:0]   idx,
    output wire [N-1:0] onehot
);

    function [7:0] first_set;
        input [N-1:0] v;
        integer i;
        begin
            first_set = 8'h00;
            for (i = N - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[7:0];
                end
            end
        end
    endfunction

    wire [N-1:0] gated;

    assign gated  = gie ? req : {N{1'b0}};
    assign any    = |gated;
    // Lowest index sits at the lowest vector and wins.
    assign idx    = first_set(gated);
    assign onehot = any ? ({{(N-1){1'b0}}, 1'b1} << idx) : {N{1'b0}};

endmodule // cie_prio

// ===== logic/cie_core.v
// Interrupt acceptance, entry, return, stack pointer and core flags.
`timescale 1ns/1ns
`include "cie_defines.vh"
// Notes on behaviour
// - Take only when source and global enabled.
// - Lowest vector first; reset highest.
// - Taking an interrupt clears global enable.
// - Global enable set inside handler allows nesting.
// - Return instruction sets global enable.
// - Taken flag source vectors and clears flag.
// - Writing one clears pending flag.
// - Disabled flags stay latched, served later.
// - Level sources request only while present.
// - One instruction runs after return first.
// - Core flags never saved or restored.
// - Clear-enable acts at once, same cycle.
// - Instruction after set-enable runs first.
// - Entry four cycles, pushes return address.
// - Vector jump takes three cycles.
// - Multi-cycle instruction completes before taking.
// - Wake from sleep adds four cycles.
// - Return four cycles, pops, adds two.
// - Stack pointer 16 bits, reset top.
// - Core flags layout, read/write, reset zero; S bit ignores writes.
// - Sign equals negative xor overflow.
// - Bit-copy flag for store and load.
// - Entry push lowers stack pointer two.
module cie_core #(
    parameter        NF         = 4,
    parameter        NL         = 2,
    parameter [15:0] TOP_OF_RAM = 16'h015f,
    parameter [15:0] VEC_BASE   = 16'h0000,
    parameter [15:0] VEC_STEP   = 16'h0001
) (
    // Clock and reset
    input  wire          clk,
    input  wire          arst_n,
    // Register access port
    input  wire [6:0]    io_addr,
    input  wire          io_wr,
    input  wire          io_rd,
    input  wire [7:0]    io_wdata,
    output reg  [7:0]    io_rdata,
    // Interrupt sources
    input  wire [NF-1:0] flag_event,
    input  wire [NL-1:0] level_req,
    // Sequencer
    input  wire          instr_boundary,
    input  wire          sleeping,
    input  wire          op_set_gie,
    input  wire          op_clear_gie,
    input  wire          return_from_handler,
    input  wire [15:0]   pc_now,
    output wire          busy,
    output reg           pc_load,
    output reg  [15:0]   pc_target,
    output reg           taken,
    // ALU and bit copy
    input  wire          alu_we,
    input  wire [7:0]    alu_flags,
    input  wire          bit_store_op,
    input  wire          bit_store_val,
    output wire          bit_load_val,
    // Stack memory
    output wire          stk_we,
    output wire          stk_re,
    output wire [15:0]   stk_addr,
    output wire [7:0]    stk_wdata,
    input  wire [7:0]    stk_rdata,
    // Visible state
    output wire [7:0]    core_flags,
    output wire [15:0]   stack_pointer,
    output wire [NF-1:0] pend_flags
);

    localparam NS = NF + NL;

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_WAKE  = 3'h1;
    localparam [2:0] ST_ENTRY = 3'h2;
    localparam [2:0] ST_RET   = 3'h3;

    function [7:0] pack_flags;
        input gie, t, h, v, n, z, c;
        begin
            pack_flags = 8'h00;
            pack_flags[`CIE_BIT_GIE] = gie;
            pack_flags[`CIE_BIT_T]   = t;
            pack_flags[`CIE_BIT_H]   = h;
            pack_flags[`CIE_BIT_S]   = n ^ v;
            pack_flags[`CIE_BIT_V]   = v;
            pack_flags[`CIE_BIT_N]   = n;
            pack_flags[`CIE_BIT_Z]   = z;
            pack_flags[`CIE_BIT_C]   = c;
        end
    endfunction

    // Reset release through two flip-flops.
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // State.
    reg  [2:0]    state_reg;
    reg  [2:0]    cnt_reg;
    reg  [15:0]   sp_reg;
    reg  [15:0]   ret_pc_reg;
    reg  [7:0]    ret_hi_reg;
    reg  [15:0]   vec_reg;
    reg  [7:0]    enable_reg;
    reg           defer_reg;
    reg           gie_reg;
    reg           t_reg;
    reg           h_reg;
    reg           v_reg;
    reg           n_reg;
    reg           z_reg;
    reg           c_reg;
    wire [NF-1:0] pend_reg;

    // Register decode.
    wire wr_pend  = io_wr && (io_addr == `CIE_OFS_PEND);
    wire wr_en    = io_wr && (io_addr == `CIE_OFS_ENABLE);
    wire wr_spl   = io_wr && (io_addr == `CIE_OFS_SP_LOW);
    wire wr_sph   = io_wr && (io_addr == `CIE_OFS_SP_HIGH);
    wire wr_flags = io_wr && (io_addr == `CIE_OFS_CORE_FLAGS);

    // Clear-enable masks requests in its own cycle.
    wire gie_eff = gie_reg && !op_clear_gie;

    // Level sources carry no latch and vanish with their condition.
    wire [NS-1:0] req_all = {level_req, pend_reg} & enable_reg[NS-1:0];

    wire          win_any;
    wire [7:0]    win_idx;
    wire [NS-1:0] win_onehot;

    cie_prio #(
        .N      (NS)
    ) u_prio (
        .req    (req_all),
        .gie    (gie_eff),
        .any    (win_any),
        .idx    (win_idx),
        .onehot (win_onehot)
    );

    // Sleep has no boundaries, so a waiting request is taken directly.
    wire at_boundary = instr_boundary || sleeping;
    wire take = (state_reg == ST_IDLE) && win_any && at_boundary && !defer_reg;

    wire [NF-1:0] hw_ack = take ? win_onehot[NF-1:0] : {NF{1'b0}};
    wire [NF-1:0] sw_clr = wr_pend ? io_wdata[NF-1:0] : {NF{1'b0}};

    cie_pend #(
        .N        (NF)
    ) u_pend (
        .clk      (clk),
        .rst_n    (rst_n),
        .event_in (flag_event),
        .sw_clear (sw_clr),
        .hw_ack   (hw_ack),
        .pend_reg (pend_reg)
    );

    wire start_ret = (state_reg == ST_IDLE) && return_from_handler && !take;
    wire in_entry  = (state_reg == ST_ENTRY);
    wire in_ret    = (state_reg == ST_RET);
    wire ret_done  = in_ret && (cnt_reg == `CIE_RETURN_CYCLES - 3'h1);
    wire entry_end = in_entry && (cnt_reg == `CIE_ENTRY_CYCLES - 3'h1);
    wire [15:0] vec_now = VEC_BASE + VEC_STEP * (16'h0001 + {8'h00, win_idx});

    // Sequencer, entry and return.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 3'h0;
            ret_pc_reg <= 16'h0000;
            ret_hi_reg <= 8'h00;
            vec_reg    <= 16'h0000;
            pc_load    <= 1'b0;
            pc_target  <= 16'h0000;
            taken      <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            taken   <= take;
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 3'h0;
                    if (take) begin
                        ret_pc_reg <= pc_now;
                        vec_reg    <= vec_now;
                        state_reg  <= sleeping ? ST_WAKE : ST_ENTRY;
                    end else if (return_from_handler) begin
                        state_reg <= ST_RET;
                    end
                end
                ST_WAKE: begin
                    if (cnt_reg == `CIE_WAKE_EXTRA - 3'h1) begin
                        cnt_reg   <= 3'h0;
                        state_reg <= ST_ENTRY;
                    end else begin
                        cnt_reg <= cnt_reg + 3'h1;
                    end
                end
                ST_ENTRY: begin
                    if (entry_end) begin
                        // The vector holds a jump the sequencer runs in
                        // its own cycles after this load.
                        pc_load   <= 1'b1;
                        pc_target <= vec_reg;
                        cnt_reg   <= 3'h0;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 3'h1;
                    end
                end
                ST_RET: begin
                    if (cnt_reg == 3'h1) begin
                        ret_hi_reg <= stk_rdata;
                    end
                    // The low byte is valid only in the cycle after its read, so keep it here.
                    if (cnt_reg == 3'h2) begin
                        ret_pc_reg <= {ret_hi_reg, stk_rdata};
                    end
                    if (ret_done) begin
                        pc_load   <= 1'b1;
                        pc_target <= ret_pc_reg;
                        cnt_reg   <= 3'h0;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 3'h1;
                    end
                end
                default: begin
                    cnt_reg   <= 3'h0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Low byte goes out first, high byte one address lower.
    assign stk_we = in_entry && (cnt_reg < 3'h2);
    assign stk_re = in_ret && (cnt_reg < 3'h2);
    assign stk_wdata = (cnt_reg == 3'h0) ? ret_pc_reg[7:0] : ret_pc_reg[15:8];
    assign stk_addr = in_entry ? (sp_reg - {13'h0000, cnt_reg}) :
                      (sp_reg + 16'h0001 + {13'h0000, cnt_reg});
    assign busy = (state_reg != ST_IDLE) || start_ret;

    // Stack pointer.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_reg <= TOP_OF_RAM;
        end else if (in_entry && cnt_reg == 3'h1) begin
            sp_reg <= sp_reg - 16'h0002;
        end else if (in_ret && cnt_reg == 3'h1) begin
            sp_reg <= sp_reg + 16'h0002;
        end else if (wr_spl) begin
            sp_reg <= {sp_reg[15:8], io_wdata};
        end else if (wr_sph) begin
            sp_reg <= {io_wdata, sp_reg[7:0]};
        end
    end

    // Global enable and the one-instruction hold-off.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gie_reg   <= 1'b0;
            defer_reg <= 1'b0;
        end else begin
            if (take) begin
                gie_reg <= 1'b0;
            end else if (ret_done) begin
                gie_reg <= 1'b1;
            end else if (op_clear_gie) begin
                gie_reg <= 1'b0;
            end else if (op_set_gie) begin
                gie_reg <= 1'b1;
            end else if (wr_flags) begin
                gie_reg <= io_wdata[`CIE_BIT_GIE];
            end
            // Setting the hold-off wins over its use at a boundary.
            if (ret_done || (op_set_gie && !gie_reg)) begin
                defer_reg <= 1'b1;
            end else if (instr_boundary) begin
                defer_reg <= 1'b0;
            end
        end
    end

    // Arithmetic flags and bit copy; entry and return leave them alone.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t_reg <= 1'b0;
            h_reg <= 1'b0;
            v_reg <= 1'b0;
            n_reg <= 1'b0;
            z_reg <= 1'b0;
            c_reg <= 1'b0;
        end else if (wr_flags) begin
            t_reg <= io_wdata[`CIE_BIT_T];
            h_reg <= io_wdata[`CIE_BIT_H];
            v_reg <= io_wdata[`CIE_BIT_V];
            n_reg <= io_wdata[`CIE_BIT_N];
            z_reg <= io_wdata[`CIE_BIT_Z];
            c_reg <= io_wdata[`CIE_BIT_C];
        end else begin
            if (bit_store_op) begin
                t_reg <= bit_store_val;
            end
            if (alu_we) begin
                h_reg <= alu_flags[`CIE_BIT_H];
                v_reg <= alu_flags[`CIE_BIT_V];
                n_reg <= alu_flags[`CIE_BIT_N];
                z_reg <= alu_flags[`CIE_BIT_Z];
                c_reg <= alu_flags[`CIE_BIT_C];
            end
        end
    end

    assign core_flags = pack_flags(gie_reg, t_reg, h_reg, v_reg, n_reg, z_reg, c_reg);
    assign bit_load_val  = t_reg;
    assign stack_pointer = sp_reg;
    assign pend_flags    = pend_reg;

    // Enable register and read data.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= `CIE_RST_ENABLE;
            io_rdata   <= 8'h00;
        end else begin
            if (wr_en) begin
                enable_reg <= io_wdata;
            end
            if (io_rd) begin
                case (io_addr)
                    `CIE_OFS_PEND:       io_rdata <= {{(8-NF){1'b0}}, pend_reg};
                    `CIE_OFS_ENABLE:     io_rdata <= enable_reg;
                    `CIE_OFS_SP_LOW:     io_rdata <= sp_reg[7:0];
                    `CIE_OFS_SP_HIGH:    io_rdata <= sp_reg[15:8];
                    `CIE_OFS_CORE_FLAGS: io_rdata <= core_flags;
                    default:             io_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // cie_core

// ===== testbench/cie_monitor.sv
// Assertion checker for the interrupt entry and return block.
`timescale 1ns/1ns
module cie_monitor (
    // Clock, reset and sequencer
    input wire        clk,
    input wire        arst_n,
    input wire        op_clear_gie,
    input wire        instr_boundary,
    input wire        sleeping,
    input wire        bit_store_op,
    input wire        bit_store_val,
    // Observed outputs
    input wire        bit_load_val,
    input wire        taken,
    input wire        pc_load,
    input wire        stk_we,
    input wire        stk_re,
    input wire [15:0] stk_addr,
    input wire [15:0] stack_pointer,
    input wire [7:0]  core_flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Low byte goes to the current top, high byte one below it.
    sequence push_pair;
        (stk_we && stk_addr == stack_pointer) ##1 (stk_we && stk_addr == stack_pointer - 16'h1);
    endsequence
    sequence pop_pair;
        (stk_re && stk_addr == stack_pointer + 16'h1) ##1 (stk_re && stk_addr == stack_pointer + 16'h2);
    endsequence

    a_entry_push_order: assert property (taken && !$past(sleeping) |-> push_pair
        ##1 (stack_pointer == $past(stack_pointer, 2) - 16'h2) ##2 pc_load)
        else $error("entry sequence out of order");
    a_take_needs_gate: assert property (taken |-> $past(core_flags[7]) && !$past(op_clear_gie)
        && $past(instr_boundary || sleeping))
        else $error("take without enable or boundary");
    a_take_clears_gie: assert property (taken |-> !core_flags[7])
        else $error("global enable still set after take");
    a_return_pop_order: assert property ($rose(stk_re) |-> pop_pair
        ##1 (stack_pointer == $past(stack_pointer, 2) + 16'h2) ##2 (pc_load && core_flags[7]))
        else $error("return sequence out of order");
    a_sign_is_xor: assert property (core_flags[4] == (core_flags[2] ^ core_flags[3]))
        else $error("sign flag differs from negative xor overflow");
    a_bit_copy_load: assert property ($past(bit_store_op) |->
        bit_load_val == $past(bit_store_val) && core_flags[6] == bit_load_val)
        else $error("bit copy flag not stored");
    a_load_one_cycle: assert property (pc_load |=> !pc_load)
        else $error("load pulse too long");
    a_taken_one_cycle: assert property (taken |=> !taken)
        else $error("take pulse too long");
endmodule // cie_monitor

bind cie_core cie_monitor i_mon (.clk(clk), .arst_n(arst_n), .op_clear_gie(op_clear_gie),
    .instr_boundary(instr_boundary), .sleeping(sleeping), .bit_store_op(bit_store_op),
    .bit_store_val(bit_store_val), .bit_load_val(bit_load_val), .taken(taken), .pc_load(pc_load),
    .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr), .stack_pointer(stack_pointer),
    .core_flags(core_flags));

// ===== testbench/cie_stack_model.sv
// Stack memory model on the far side of the block.
`timescale 1ns/1ns
module cie_stack_model (
    // Clock
    input wire         clk,
    // Stack port
    input wire         stk_we,
    input wire         stk_re,
    input wire [15:0]  stk_addr,
    input wire [7:0]   stk_wdata,
    output logic [7:0] stk_rdata
);
    logic [7:0] mem [0:65535];

    initial stk_rdata = 8'h00;
    // Outside a read the bus toggles, so a stale byte can never pass for a popped one.
    always @(posedge clk) begin
        if (stk_we) begin
            mem[stk_addr] <= stk_wdata;
        end
        stk_rdata <= stk_re ? mem[stk_addr] : ~stk_rdata;
    end
endmodule // cie_stack_model

// ===== testbench/tb_cie_core.sv
// Self-checking testbench for the interrupt entry and return block.
`timescale 1ns/1ns
`include "cie_defines.vh"
module tb_cie_core;
    localparam [15:0] TOP = 16'h015f;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [6:0]  io_addr = 7'h00;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [3:0]  flag_event = 4'h0;
    logic [1:0]  level_req = 2'h0;
    logic        instr_boundary = 1'b0;
    logic        sleeping = 1'b0;
    logic        op_set_gie = 1'b0;
    logic        op_clear_gie = 1'b0;
    logic        return_from_handler = 1'b0;
    logic [15:0] pc_now = 16'h0000;
    logic        alu_we = 1'b0;
    logic [7:0]  alu_flags = 8'h00;
    logic        bit_store_op = 1'b0;
    logic        bit_store_val = 1'b0;
    wire  [7:0]  io_rdata, stk_wdata, stk_rdata, core_flags;
    wire  [15:0] pc_target, stk_addr, stack_pointer;
    wire  [3:0]  pend_flags;
    wire         busy, pc_load, taken, bit_load_val, stk_we, stk_re;
    int          fail_count = 0;
    int          checks_done = 0;

    always #50 clk = ~clk;

    cie_core #(.NF(4), .NL(2), .TOP_OF_RAM(TOP)) i_dut (.clk(clk), .arst_n(arst_n), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .flag_event(flag_event),
        .level_req(level_req), .instr_boundary(instr_boundary), .sleeping(sleeping),
        .op_set_gie(op_set_gie), .op_clear_gie(op_clear_gie), .return_from_handler(return_from_handler),
        .pc_now(pc_now), .busy(busy), .pc_load(pc_load), .pc_target(pc_target), .taken(taken),
        .alu_we(alu_we), .alu_flags(alu_flags), .bit_store_op(bit_store_op), .bit_store_val(bit_store_val),
        .bit_load_val(bit_load_val), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
        .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .core_flags(core_flags),
        .stack_pointer(stack_pointer), .pend_flags(pend_flags));
    cie_stack_model i_stk (.clk(clk), .stk_we(stk_we), .stk_re(stk_re), .stk_addr(stk_addr),
        .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

    task automatic give_verdict();
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobes are dropped and a clock passes before the next access, so calls may follow at once.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        tick();
        io_wr = 1'b0;
        tick();
    endtask
    task automatic rd(input string what, input logic [6:0] a, input logic [7:0] exp);
        io_addr = a;
        io_rd = 1'b1;
        tick();
        chk(what, {8'h00, io_rdata}, {8'h00, exp});
        io_rd = 1'b0;
        tick();
    endtask
    task automatic wait_load(input int n, input logic [15:0] pc);
        int k;
        k = 0;
        while (pc_load !== 1'b1 && k < 40) begin
            tick();
            k++;
        end
        if (k >= 40) begin
            fail_count++;
            give_verdict();
        end else begin
            chk("load_cycles", k[15:0], n[15:0]);
            chk("pc_target", pc_target, pc);
            chk("busy_idle", {15'h0, busy}, 16'h0000);
        end
    endtask
    task automatic nb();
        instr_boundary = 1'b1;
        tick();
        chk("no_take", {15'h0, taken}, 16'h0);
        instr_boundary = 1'b0;
        tick();
    endtask
    task automatic take(input logic [15:0] vec);
        instr_boundary = 1'b1;
        tick();
        chk("taken", {15'h0, taken}, 16'h0001);
        chk("busy_entry", {15'h0, busy}, 16'h0001);
        instr_boundary = 1'b0;
        wait_load(4, vec);
    endtask
    task automatic ret(input logic [15:0] pc);
        return_from_handler = 1'b1;
        tick();
        chk("busy_ret", {15'h0, busy}, 16'h0001);
        return_from_handler = 1'b0;
        wait_load(4, pc);
    endtask
    task automatic sei();
        op_set_gie = 1'b1;
        tick();
        op_set_gie = 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (3) tick();
        rd("flags_rst", 7'h5f, 8'h00);
        rd("spl_rst", 7'h5d, TOP[7:0]);
        rd("sph_rst", 7'h5e, TOP[15:8]);
        rd("unmapped", 7'h40, 8'h00);
        wr(7'h5d, 8'h80);
        wr(7'h5e, 8'h02);
        rd("spl_rw", 7'h5d, 8'h80);
        rd("sph_rw", 7'h5e, 8'h02);
        wr(7'h5f, 8'hff);
        rd("flags_rw", 7'h5f, 8'hef);
        wr(7'h5f, 8'h04);
        rd("sign_set", 7'h5f, 8'h14);
        alu_flags = 8'h2f;
        alu_we = 1'b1;
        tick();
        alu_we = 1'b0;
        chk("alu_flags", {8'h00, core_flags}, 16'h002f);
        bit_store_val = 1'b1;
        bit_store_op = 1'b1;
        tick();
        bit_store_op = 1'b0;
        chk("bit_copy", {8'h00, core_flags}, 16'h006f);
        wr(7'h5b, 8'h1d);
        flag_event = 4'h2;
        tick();
        flag_event = 4'h0;
        sei();
        nb();
        nb();
        chk("pend_kept", {12'h0, pend_flags}, 16'h0002);
        wr(7'h5a, 8'h01);
        chk("pend_w0", {12'h0, pend_flags}, 16'h0002);
        wr(7'h5a, 8'h02);
        chk("pend_w1", {12'h0, pend_flags}, 16'h0000);
        op_clear_gie = 1'b1;
        tick();
        op_clear_gie = 1'b0;
        flag_event = 4'h5;
        tick();
        flag_event = 4'h0;
        chk("pend_latch", {12'h0, pend_flags}, 16'h0005);
        pc_now = 16'h1234;
        sei();
        nb();
        take(16'h0001);
        chk("pend_hw_clr", {12'h0, pend_flags}, 16'h0004);
        chk("pushed", {i_stk.mem[16'h027f], i_stk.mem[16'h0280]}, 16'h1234);
        chk("sp_push", stack_pointer, 16'h027e);
        chk("gie_clr", {8'h00, core_flags}, 16'h006f);
        sei();
        nb();
        op_clear_gie = 1'b1;
        nb();
        op_clear_gie = 1'b0;
        pc_now = 16'h0101;
        sei();
        nb();
        take(16'h0003);
        level_req = 2'h1;
        pc_now = 16'h0202;
        sei();
        nb();
        take(16'h0005);
        level_req = 2'h0;
        flag_event = 4'h1;
        tick();
        flag_event = 4'h0;
        ret(16'h0202);
        chk("gie_ret", {8'h00, core_flags}, 16'h00ef);
        chk("sp_pop", stack_pointer, 16'h027c);
        nb();
        pc_now = 16'h0303;
        take(16'h0001);
        ret(16'h0303);
        ret(16'h0101);
        ret(16'h1234);
        chk("sp_final", stack_pointer, 16'h0280);
        nb();
        pc_now = 16'h0404;
        flag_event = 4'h8;
        sleeping = 1'b1;
        tick();
        flag_event = 4'h0;
        wait_load(`CIE_ENTRY_CYCLES + `CIE_WAKE_EXTRA + 1, 16'h0004);
        sleeping = 1'b0;
        give_verdict();
    end
endmodule // tb_cie_core
